// ==== inc/pin_function_select_pkg.sv ====
// Purpose: Shared constants for the pin function select block
// Assumes: 32-bit APB register access, one aligned word per register
// Notes: Field codes are 4 bits, one field per pin
package pin_function_select_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] OFFSET_SEL_FIVE = 12'h000;
  localparam logic [11:0] OFFSET_SEL_SIX = 12'h004;
  localparam logic [31:0] RESET_SEL = 32'h0000_0000;
  localparam int FIELD_WIDTH = 4;

  // Field positions (low bit of each nibble)
  localparam int LSB_SEL5_BITS7_4 = 4;
  localparam int LSB_SEL5_BITS3_0 = 0;
  localparam int LSB_SEL6_BITS31_28 = 28;
  localparam int LSB_SEL6_BITS27_24 = 24;
  localparam int LSB_SEL6_BITS23_20 = 20;
  localparam int LSB_SEL6_BITS19_16 = 16;
  localparam int LSB_SEL6_BITS15_12 = 12;

  // ************************************************************
  // Function codes
  // ************************************************************
  localparam logic [3:0] CODE_ZERO = 4'h0;
  localparam logic [3:0] CODE_ONE = 4'h1;
  localparam logic [3:0] CODE_TWO = 4'h2;
  localparam logic [3:0] CODE_FOUR = 4'h4;
  localparam logic [3:0] CODE_GPIO = 4'h8;

  // Per-lane masks, bit k set when code k drives or samples the pin
  localparam logic [15:0] DRIVE_TIMER_LANE = 16'h0016;
  localparam logic [15:0] SINK_TIMER_LANE = 16'h0001;
  localparam logic [15:0] DRIVE_STROBE_LANE = 16'h0002;
  localparam logic [15:0] SINK_STROBE_LANE = 16'h0000;
  localparam logic [15:0] DRIVE_WAIT_LANE = 16'h0010;
  localparam logic [15:0] SINK_WAIT_LANE = 16'h0003;
  localparam logic [15:0] DRIVE_CAS_LANE = 16'h0012;
  localparam logic [15:0] SINK_CAS_LANE = 16'h0001;

  // Pull one selection field out of a register word
  function automatic logic [3:0] field_of(input logic [31:0] word, input int lsb);
    field_of = word[lsb +: FIELD_WIDTH];
  endfunction : field_of

  // Place function sources at code positions 1, 2 and 4
  function automatic logic [15:0] src_vec(input logic c1, input logic c2, input logic c4);
    src_vec = 16'h0000;
    src_vec[1] = c1;
    src_vec[2] = c2;
    src_vec[4] = c4;
  endfunction : src_vec

endpackage : pin_function_select_pkg

// ==== logic/pin_lane.sv ====
// Purpose: One multiplexed pin, steered by its 4-bit selection field
// Assumes: Inputs synchronous to i_clk
// Notes: Outputs are registered, so a field change reaches the pin one edge later
`timescale 1ns/1ps
module pin_lane
  import pin_function_select_pkg::*;
#(
  parameter logic [15:0] DRIVE_MASK = 16'h0000,
  parameter logic [15:0] SINK_MASK = 16'h0000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_code,
  input wire logic [15:0] i_src,
  input wire logic i_gpio_out,
  input wire logic i_gpio_drive,
  input wire logic i_pin_in,
  output logic o_pin_out,
  output logic o_pin_oe_n,
  output logic [15:0] o_sink
);

  logic pin_out_reg;
  logic pin_out_next;
  logic pin_oe_n_reg;
  logic pin_oe_n_next;
  logic [15:0] sink_reg;
  logic [15:0] sink_next;

  // ************************************************************
  // Selection decode
  // ************************************************************
  // Reserved codes hit no mask bit: driver off, nothing sampled
  always_comb begin
    pin_out_next = 1'b0;
    pin_oe_n_next = 1'b1;
    sink_next = 16'h0000;
    if (i_code == CODE_GPIO) begin
      pin_out_next = i_gpio_out;
      pin_oe_n_next = ~i_gpio_drive;
      sink_next[CODE_GPIO] = i_pin_in;
    end else begin
      if (DRIVE_MASK[i_code]) begin
        pin_out_next = i_src[i_code];
        pin_oe_n_next = 1'b0;
      end
      if (SINK_MASK[i_code]) begin
        sink_next[i_code] = i_pin_in;
      end
    end
  end

  // Register pin and sink values; driver off in reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      sink_reg <= 16'h0000;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
      sink_reg <= sink_next;
    end
  end

  assign o_pin_out = pin_out_reg;
  assign o_pin_oe_n = pin_oe_n_reg;
  assign o_sink = sink_reg;

endmodule : pin_lane

// ==== logic/pin_function_select.sv ====
// Purpose: Pin function selection registers and seven multiplexed pins
// Assumes: APB slave, 32-bit data, inputs synchronous to i_clk
// Notes: Every access answers one cycle after the access phase starts
//   Unmapped offsets answer with pslverr and drop the write
//   Pins and sinks are registered and follow a field change one edge later
//
// Functional notes
// - Fifth register low two fields: timer, chip select, PWM, unit output, GPIO
// - Sixth register fields 31-28, 23-20, 19-16: hi-Z, memory strobe, GPIO
// - Sixth register fields 27-24, 15-12: unit input, memory wait/CAS, output, GPIO
// - Each register holds eight nibble fields; only seven of the sixteen steer a pin
// - All fields read/write and cleared to zero on reset
`timescale 1ns/1ps
module pin_function_select
  import pin_function_select_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins, index 0..6 in field order
  input wire logic [6:0] i_pin_in,
  output logic [6:0] o_pin_out,
  output logic [6:0] o_pin_oe_n,
  // Function sources
  input wire logic [1:0] i_serial1_chip_select,
  input wire logic i_pwm1_output_a,
  input wire logic i_pwm1_output_b,
  input wire logic [3:0] i_prog_unit0_output_bit,
  input wire logic i_ext_mem_chip_select,
  input wire logic [1:0] i_ext_mem_write_mask,
  input wire logic i_ext_mem_column_strobe,
  input wire logic [6:0] i_gpio_bank2_out,
  input wire logic [6:0] i_gpio_bank2_drive,
  // Function sinks
  output logic o_timer3_input,
  output logic o_timer2_input,
  output logic [1:0] o_prog_unit0_input_bit,
  output logic o_ext_mem_wait,
  output logic [6:0] o_gpio_bank2_pin
);

  // ************************************************************
  // APB slave
  // ************************************************************
  // One wait state: idle takes the access, the response state answers
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } bus_state_e;

  // Bus state, both selection words and the registered answer
  bus_state_e state_reg;
  bus_state_e state_next;
  logic [31:0] sel_five_reg;
  logic [31:0] sel_five_next;
  logic [31:0] sel_six_reg;
  logic [31:0] sel_six_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic hit_five;
  logic hit_six;
  logic commit;

  // Full 12-bit compare, so neither word shows up again at a higher offset
  assign hit_five = (i_paddr == OFFSET_SEL_FIVE);
  assign hit_six = (i_paddr == OFFSET_SEL_SIX);
  // Write lands only on the edge where pready is seen high
  assign commit = (state_reg == ST_RESP) && i_psel && i_penable;

  // Next-state, read data and register writes
  always_comb begin
    state_next = state_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    sel_five_next = sel_five_reg;
    sel_six_next = sel_six_reg;
    case (state_reg)
      ST_IDLE: begin
        // Access phase seen: answer next cycle with data or an error
        if (i_psel && i_penable) begin
          state_next = ST_RESP;
          pslverr_next = ~(hit_five | hit_six); // Unmapped answers with an error
          prdata_next = 32'h0000_0000;
          if (!i_pwrite && hit_five) begin
            prdata_next = sel_five_reg;
          end
          if (!i_pwrite && hit_six) begin
            prdata_next = sel_six_reg;
          end
        end
      end
      ST_RESP: begin
        // Ready is high now; a write lands on this edge only
        state_next = ST_IDLE;
        pslverr_next = 1'b0;
        prdata_next = 32'h0000_0000;
        if (commit && i_pwrite && hit_five) begin
          sel_five_next = i_pwdata;
        end
        if (commit && i_pwrite && hit_six) begin
          sel_six_next = i_pwdata;
        end
      end
      default: begin
        // Illegal state code: back to idle with quiet outputs
        state_next = ST_IDLE;
        pslverr_next = 1'b0;
        prdata_next = 32'h0000_0000;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Bus and selection registers; fields clear to zero on reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      sel_five_reg <= RESET_SEL;
      sel_six_reg <= RESET_SEL;
    end else begin
      state_reg <= state_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      sel_five_reg <= sel_five_next;
      sel_six_reg <= sel_six_next;
    end
  end

  // Bus outputs come straight from flops; pready is the response state bit
  assign o_prdata = prdata_reg;
  assign o_pready = state_reg[1];
  assign o_pslverr = pslverr_reg;

  // ************************************************************
  // Pin lanes
  // ************************************************************
  // Per-lane code, source vector and registered sink vector
  logic [3:0] lane_code [7];
  logic [15:0] lane_src [7];
  logic [15:0] lane_sink [7];

  // ************************************************************
  // Codes and sources
  // ************************************************************
  // Field per lane; unused nibbles of both words store but steer nothing
  assign lane_code[0] = field_of(sel_five_reg, LSB_SEL5_BITS7_4);
  assign lane_code[1] = field_of(sel_five_reg, LSB_SEL5_BITS3_0);
  assign lane_code[2] = field_of(sel_six_reg, LSB_SEL6_BITS31_28);
  assign lane_code[3] = field_of(sel_six_reg, LSB_SEL6_BITS27_24);
  assign lane_code[4] = field_of(sel_six_reg, LSB_SEL6_BITS23_20);
  assign lane_code[5] = field_of(sel_six_reg, LSB_SEL6_BITS19_16);
  assign lane_code[6] = field_of(sel_six_reg, LSB_SEL6_BITS15_12);

  // Output sources placed at their code positions
  assign lane_src[0] = src_vec(i_serial1_chip_select[0], i_pwm1_output_b,
                               i_prog_unit0_output_bit[0]);
  assign lane_src[1] = src_vec(i_serial1_chip_select[1], i_pwm1_output_a,
                               i_prog_unit0_output_bit[1]);
  assign lane_src[2] = src_vec(i_ext_mem_chip_select, 1'b0, 1'b0);
  assign lane_src[3] = src_vec(1'b0, 1'b0, i_prog_unit0_output_bit[2]);
  assign lane_src[4] = src_vec(i_ext_mem_write_mask[1], 1'b0, 1'b0);
  assign lane_src[5] = src_vec(i_ext_mem_write_mask[0], 1'b0, 1'b0);
  assign lane_src[6] = src_vec(i_ext_mem_column_strobe, 1'b0,
                               i_prog_unit0_output_bit[3]);

  // ************************************************************
  // Lane decode tables
  // ************************************************************
  // Hazard: a wrong mask bit here would let a reserved code drive a pin
  // Lane kinds differ only in which codes drive and which sample
  localparam logic [15:0] DRIVE_TAB [7] = '{DRIVE_TIMER_LANE, DRIVE_TIMER_LANE,
    DRIVE_STROBE_LANE, DRIVE_WAIT_LANE, DRIVE_STROBE_LANE, DRIVE_STROBE_LANE,
    DRIVE_CAS_LANE};
  localparam logic [15:0] SINK_TAB [7] = '{SINK_TIMER_LANE, SINK_TIMER_LANE,
    SINK_STROBE_LANE, SINK_WAIT_LANE, SINK_STROBE_LANE, SINK_STROBE_LANE,
    SINK_CAS_LANE};

  // ************************************************************
  // Lane instances
  // ************************************************************
  // One lane per steered field; lanes 2, 4 and 5 sample the pin only as GPIO
  for (genvar g = 0; g < 7; g++) begin : g_lane
    pin_lane #(
      .DRIVE_MASK(DRIVE_TAB[g]),
      .SINK_MASK(SINK_TAB[g])
    ) u_lane (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_code(lane_code[g]),
      .i_src(lane_src[g]),
      .i_gpio_out(i_gpio_bank2_out[g]),
      .i_gpio_drive(i_gpio_bank2_drive[g]),
      .i_pin_in(i_pin_in[g]),
      .o_pin_out(o_pin_out[g]),
      .o_pin_oe_n(o_pin_oe_n[g]),
      .o_sink(lane_sink[g])
    );
    assign o_gpio_bank2_pin[g] = lane_sink[g][CODE_GPIO];
  end

  // ************************************************************
  // Function sinks
  // ************************************************************
  // Sampled functions, each from its lane's registered sink
  assign o_timer3_input = lane_sink[0][CODE_ZERO];
  assign o_timer2_input = lane_sink[1][CODE_ZERO];
  assign o_prog_unit0_input_bit[0] = lane_sink[3][CODE_ZERO];
  assign o_prog_unit0_input_bit[1] = lane_sink[6][CODE_ZERO];
  assign o_ext_mem_wait = lane_sink[3][CODE_ONE];

endmodule : pin_function_select

// ==== testbench/pin_function_select_assertions.sv ====
// Purpose: Port-level checks of the pin function select block
// Assumes: One clock domain, reset asynchronous and active low
// Notes: Sinks are registered, so they trail the pin level by one edge
`timescale 1ns/1ps
module pin_function_select_assertions
  import pin_function_select_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [6:0] i_pin_in,
  input wire logic [6:0] o_pin_out,
  input wire logic [6:0] o_pin_oe_n,
  input wire logic i_ext_mem_chip_select,
  input wire logic [6:0] i_gpio_bank2_out,
  input wire logic o_timer3_input,
  input wire logic [6:0] o_gpio_bank2_pin
);
  // ****************************************
  // Bus and lane properties
  // ****************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_answer; i_psel && i_penable && !o_pready |=> o_pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer to access");
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_cause; o_pready |-> $past(i_penable); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_err;
    i_psel && i_penable && !o_pready && i_paddr != OFFSET_SEL_FIVE
      && i_paddr != OFFSET_SEL_SIX |=> o_pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_quiet; !o_pready |-> o_prdata == 32'h0 && !o_pslverr; endproperty
  a_quiet: assert property (p_quiet) else $error("bus outputs not idle");
  property p_timer; o_timer3_input |-> $past(i_pin_in[0]); endproperty
  a_timer: assert property (p_timer) else $error("timer sink not pin level");
  property p_gpio; (o_gpio_bank2_pin & ~$past(i_pin_in)) == 7'h0; endproperty
  a_gpio: assert property (p_gpio) else $error("gpio sink not pin level");
  property p_cs;
    !o_pin_oe_n[2] |-> o_pin_out[2] == $past(i_ext_mem_chip_select)
      || o_pin_out[2] == $past(i_gpio_bank2_out[2]);
  endproperty
  a_cs: assert property (p_cs) else $error("strobe lane drives foreign data");
  property p_excl; !(o_timer3_input && o_gpio_bank2_pin[0]); endproperty
  a_excl: assert property (p_excl) else $error("two functions on one pin");
endmodule : pin_function_select_assertions

bind pin_function_select pin_function_select_assertions u_chk (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pin_in(i_pin_in),
  .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
  .i_ext_mem_chip_select(i_ext_mem_chip_select), .i_gpio_bank2_out(i_gpio_bank2_out),
  .o_timer3_input(o_timer3_input), .o_gpio_bank2_pin(o_gpio_bank2_pin));

// ==== testbench/pin_partner.sv ====
// Purpose: Package pins seen from outside the device
// Assumes: Pins have no pull, the outside drives a changing level
// Notes: Released lanes never echo the device's last value
`timescale 1ns/1ps
module pin_partner (
  input wire logic [6:0] i_out,
  input wire logic [6:0] i_oe_n,
  input wire logic [6:0] i_ext,
  output logic [6:0] o_pin
);
  // Driven lanes show the device level, released ones the outside drive
  assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext);
endmodule : pin_partner

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the pin function select block
// Assumes: Fixed one wait state answer, registered pins
// Notes: Bus results go through a queue to a monitor process
`timescale 1ns/1ps
module testbench;
  import pin_function_select_pkg::*;
  // ****************************************
  // Stimulus and design
  // ****************************************
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, w;
  logic o_pready, o_pslverr;
  logic [15:0] r1 = '0, r2 = '0, r3 = '0, s = 16'h001c;
  logic [6:0] pin_in, pin_out, oe_n;
  wire [11:0] sk;
  logic [31:0] qd[$];
  logic qe[$];
  int n_mismatch = 0, n_tests = 0;
  always #2 i_clk = ~i_clk;
  pin_function_select u_pin_function_select (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe_n(oe_n),
    .i_serial1_chip_select(r1[1:0]), .i_pwm1_output_a(r1[2]), .i_pwm1_output_b(r1[3]),
    .i_prog_unit0_output_bit(r1[7:4]), .i_ext_mem_chip_select(r1[8]),
    .i_ext_mem_write_mask(r1[10:9]), .i_ext_mem_column_strobe(r1[11]),
    .i_gpio_bank2_out(r2[6:0]), .i_gpio_bank2_drive(r2[13:7]), .o_timer3_input(sk[0]),
    .o_timer2_input(sk[1]), .o_prog_unit0_input_bit(sk[3:2]), .o_ext_mem_wait(sk[4]),
    .o_gpio_bank2_pin(sk[11:5]));
  pin_partner u_pin_partner (.i_out(pin_out), .i_oe_n(oe_n), .i_ext(r3[6:0]), .o_pin(pin_in));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // Request is held until pready is seen, so back-to-back calls are legal
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, ed, input logic ee);
    qd.push_back(ed);
    qe.push_back(ee);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // No wait limit here: only the watchdog ends a hang
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
  endtask : apb

  // New random sources, then time for pins and sinks to settle
  task draw;
    s = lfsr(s);
    r1 <= s;
    s = lfsr(s);
    r2 <= s;
    s = lfsr(s);
    r3 <= s;
    repeat (4) @(posedge i_clk);
  endtask : draw

  task check_pins(input logic [3:0] c);
    logic [6:0] d, v, p;
    logic [11:0] e;
    case (c)
      4'h1: begin
        d = 7'h77;
        v = {r1[11], r1[9], r1[10], 1'b0, r1[8], r1[1:0]};
      end
      4'h2: begin
        d = 7'h03;
        v = {5'h0, r1[2], r1[3]};
      end
      4'h4: begin
        d = 7'h4b;
        v = {r1[7], 2'b0, r1[6], 1'b0, r1[5:4]};
      end
      4'h8: begin
        d = r2[13:7];
        v = r2[6:0];
      end
      default: begin
        d = '0;
        v = '0;
      end
    endcase
    p = (d & v) | (~d & r3[6:0]);
    e = '0;
    if (c == 4'h0) e[3:0] = {p[6], p[3], p[1], p[0]};
    if (c == 4'h1) e[4] = p[3];
    if (c == 4'h8) e[11:5] = p;
    check("oe_n", 32'(oe_n), 32'({~d}));
    check("pin_out", 32'({pin_out & ~oe_n}), 32'({v & d}));
    check("sinks", 32'(sk), 32'(e));
  endtask : check_pins

  // Monitor takes the oldest expected answer at each ready
  always @(posedge i_clk) begin
    if (o_pready === 1'b1 && qd.size() > 0) begin
      check("prdata", o_prdata, qd.pop_front());
      check("pslverr", 32'(o_pslverr), 32'(qe.pop_front()));
    end else if (o_pready === 1'b1) begin
      check("unasked pready", 32'h0000_0001, 32'h0000_0000);
    end
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    end_of_test;
  end

  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    check("reset oe_n", 32'(oe_n), 32'h0000_007f);
    apb(1'b0, OFFSET_SEL_FIVE, 32'h0000_0000, RESET_SEL, 1'b0);
    apb(1'b0, OFFSET_SEL_SIX, 32'h0000_0000, RESET_SEL, 1'b0);
    s = lfsr(s);
    w = {s, lfsr(s)};
    apb(1'b1, OFFSET_SEL_FIVE, w, 32'h0000_0000, 1'b0);
    apb(1'b1, OFFSET_SEL_SIX, ~w, 32'h0000_0000, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b0, OFFSET_SEL_FIVE, 32'h0000_0000, w, 1'b0);
    apb(1'b0, OFFSET_SEL_SIX, 32'h0000_0000, ~w, 1'b0);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFFSET_SEL_FIVE, {8{c[3:0]}}, 32'h0000_0000, 1'b0);
      apb(1'b1, OFFSET_SEL_SIX, {8{c[3:0]}}, 32'h0000_0000, 1'b0);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      repeat (2) begin
        draw;
        check_pins(c[3:0]);
      end
    end
    // Mid-run reset with every field written: words and pins come back cleared
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    check("rerun oe_n", 32'(oe_n), 32'h0000_007f);
    apb(1'b0, OFFSET_SEL_FIVE, 32'h0000_0000, RESET_SEL, 1'b0);
    apb(1'b0, OFFSET_SEL_SIX, 32'h0000_0000, RESET_SEL, 1'b0);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    repeat (2) begin
      draw;
      check_pins(4'h0);
    end
    end_of_test;
  end
endmodule : testbench
